// ===== core/fsr_regs.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"

// --------------------------------------------------------------------
// --------------------------------------------------------------------
module fsr_regs import fsr_pkg::*; #(
    parameter int COOL1_MS = `FSR_COOL1_MS,
    parameter int COOL2_MS = `FSR_COOL2_MS,
    parameter int COOL3_MS = `FSR_COOL3_MS
) (
    input  wire logic        core_clk,      // device clock, 200 MHz
    input  wire logic        rstn,          // sync reset, active low
    input  wire fsr_req_t    req,           // one-cycle register access
    output logic [15:0]      rdata,         // read data, valid cycle after rd
    input  wire logic        conv_valid,    // new voltage conversion pulse
    input  wire logic [9:0]  conv_code,     // voltage conversion result
    input  wire logic        over_current,  // current above selected threshold
    input  wire logic        fuse_trip,     // energy above selected trip level
    input  wire logic        restart,       // software re-enables the channel
    output fsr_cfg_t         cfg,           // fields to the analog trim
    output logic             channel_on,    // channel allowed to conduct
    output logic             fuse_off       // pulse on every fuse shutdown
);
    localparam int     CW      = 30;
    localparam longint CPU     = `FSR_CLK_MHZ;       // cycles per microsecond
    localparam longint CW_SPAN = longint'(1) << CW;  // first count the timers cannot hold

    // -----------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------
    // a zero cool-down would retry at once and defeat the wire protection,
    // and one longer than the timers can count would wrap to a short wait
    if (COOL1_MS < 1 || COOL2_MS < 1 || COOL3_MS < 1) begin : g_cool_zero
        $error("fsr_regs: cool-down must be at least one millisecond");
    end
    if (longint'(COOL1_MS) * 1000 * CPU >= CW_SPAN) begin : g_cool1_wide
        $error("fsr_regs: first cool-down too long for the timer");
    end
    if (longint'(COOL2_MS) * 1000 * CPU >= CW_SPAN) begin : g_cool2_wide
        $error("fsr_regs: second cool-down too long for the timer");
    end
    if (longint'(COOL3_MS) * 1000 * CPU >= CW_SPAN) begin : g_cool3_wide
        $error("fsr_regs: third cool-down too long for the timer");
    end
    if (longint'(`FSR_DLY3_US) * CPU >= CW_SPAN) begin : g_dly_wide
        $error("fsr_regs: delayed turn-off too long for the timer");
    end

    // -----------------------------------------------------------------
    // register storage
    // -----------------------------------------------------------------
    // every access is a one-cycle strobe from the serial port decoder; reads
    // answer a cycle later, and only a read of the result register has a side
    // effect, which is to retire the fresh flag
    logic [9:0]  vcode_reg;
    logic        vfresh_reg;
    logic [15:0] fcfg_reg;
    logic [15:0] fcfg_next;
    logic        rd_vres;

    assign rd_vres   = req.rd && (req.addr == `FSR_VRES_OFFSET);
    assign fcfg_next = req.wdata & `FSR_FCFG_WMASK;

    // latest conversion code
    always_ff @(posedge core_clk) begin
        if (!rstn) vcode_reg <= 10'(`FSR_VRES_RESET);
        else if (conv_valid) vcode_reg <= conv_code;
    end

    // fresh flag: a conversion arriving with the read wins so it is not lost;
    // that read still returns the older code with the older flag
    always_ff @(posedge core_clk) begin
        if (!rstn) vfresh_reg <= 1'h0;
        else if (conv_valid) vfresh_reg <= 1'h1;
        else if (rd_vres) vfresh_reg <= 1'h0;
    end

    // fuse configuration, reserved bits 13-11 never stored
    always_ff @(posedge core_clk) begin
        if (!rstn) fcfg_reg <= `FSR_FCFG_RESET;
        else if (req.wr && req.addr == `FSR_FCFG_OFFSET) fcfg_reg <= fcfg_next;
    end

    // read mux; unmapped addresses read zero, reserved bits zero
    always_ff @(posedge core_clk) begin
        if (!rstn) rdata <= 16'h0000;
        else if (!req.rd) rdata <= 16'h0000;
        else if (req.addr == `FSR_VRES_OFFSET) rdata <= {5'h00, vfresh_reg, vcode_reg};
        else if (req.addr == `FSR_FCFG_OFFSET) rdata <= fcfg_reg;
        else rdata <= 16'h0000;
    end

    // field decode drives the threshold and trip level selections
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cfg <= '0;
        end else begin
            cfg.cooldown    <= fcfg_reg[`FSR_COOL_LSB +: 2];
            cfg.dly_timer   <= fcfg_reg[`FSR_DTMR_LSB +: 2];
            cfg.dly_current <= fcfg_reg[`FSR_DCUR_LSB +: 2];
            cfg.trip_level  <= fcfg_reg[`FSR_TRIP_LSB +: 4];
            cfg.nominal     <= fcfg_reg[`FSR_NOM_LSB +: 3];
        end
    end

    // -----------------------------------------------------------------
    // timing selections in cycles
    // -----------------------------------------------------------------
    logic [CW-1:0] dly_cycles;
    logic [CW-1:0] cool_cycles;
    logic [1:0]    cool_code;

    // cool-down code shared by the wait selection and the latch decision
    assign cool_code = fcfg_reg[`FSR_COOL_LSB +: 2];

    // delayed turn-off time chosen by the timer field
    always_comb begin
        case (fcfg_reg[`FSR_DTMR_LSB +: 2])
            2'h0:    dly_cycles = CW'(`FSR_DLY0_US * CPU);
            2'h1:    dly_cycles = CW'(`FSR_DLY1_US * CPU);
            2'h2:    dly_cycles = CW'(`FSR_DLY2_US * CPU);
            default: dly_cycles = CW'(`FSR_DLY3_US * CPU);
        endcase
    end

    // cool-down wait; code zero loads the third wait, which the latched state clears a cycle later
    always_comb begin
        case (cool_code)
            2'h1:    cool_cycles = CW'(longint'(COOL1_MS) * 1000 * CPU);
            2'h2:    cool_cycles = CW'(longint'(COOL2_MS) * 1000 * CPU);
            default: cool_cycles = CW'(longint'(COOL3_MS) * 1000 * CPU);
        endcase
    end

    // -----------------------------------------------------------------
    // protection state machine
    // -----------------------------------------------------------------
    fsr_state_t state_reg;
    logic       oc_reg;
    logic       dly_run;
    logic       dly_done;
    logic       cool_done;
    logic       trip_now;

    // the delay window only runs while the channel may conduct
    assign dly_run = over_current && (state_reg == FSR_ON);

    // start of a window restarts the delay timer; a retry into a still present
    // over-current opens a fresh window, otherwise the channel would stay on for good
    always_ff @(posedge core_clk) begin
        if (!rstn) oc_reg <= 1'h0;
        else oc_reg <= dly_run;
    end

    fsr_timer #(.CW(CW)) u_dly (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (dly_run && !oc_reg),
        .run      (dly_run),
        .count    (dly_cycles),
        .done     (dly_done)
    );

    fsr_timer #(.CW(CW)) u_cool (
        .core_clk (core_clk),
        .rstn     (rstn),
        .load     (trip_now),
        .run      (state_reg == FSR_COOLING || trip_now),
        .count    (cool_cycles),
        .done     (cool_done)
    );

    assign trip_now = (state_reg == FSR_ON) && (dly_done || fuse_trip);

    // shutdown leads either to timed retry or to a latched off state
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_reg <= FSR_ON;
        end else begin
            case (state_reg)
                FSR_ON: begin
                    if (trip_now) begin
                        if (cool_code == 2'h0) state_reg <= FSR_LATCHED;
                        else state_reg <= FSR_COOLING;
                    end
                end
                FSR_COOLING: begin
                    if (cool_done || restart) state_reg <= FSR_ON;
                end
                FSR_LATCHED: begin
                    if (restart) state_reg <= FSR_ON;
                end
                default: state_reg <= FSR_ON;
            endcase
        end
    end

    // channel enable drops on the same edge that reports the shutdown
    always_ff @(posedge core_clk) begin
        if (!rstn) channel_on <= 1'h0;
        else channel_on <= (state_reg == FSR_ON) && !trip_now;
    end

    // one pulse per shutdown: the state leaves FSR_ON on that edge, so it cannot repeat
    always_ff @(posedge core_clk) begin
        if (!rstn) fuse_off <= 1'h0;
        else fuse_off <= trip_now;
    end
endmodule

// ===== core/fsr_timer.sv
`timescale 1ns/1ps
`include "fsr_defs.svh"

// down counter: loads a cycle count, pulses done as it steps from one to zero
module fsr_timer import fsr_pkg::*; #(
    parameter int CW = 30
) (
    input  wire logic          core_clk,  // device clock
    input  wire logic          rstn,      // sync reset, active low
    input  wire logic          load,      // restart counting
    input  wire logic          run,       // keep counting, else clear
    input  wire logic [CW-1:0] count,     // cycles to count
    output logic               done       // one-cycle pulse at expiry
);
    // counters narrower than 24 bits are refused; the shortest protection window, 40000 cycles, fits in 16 bits
    if (CW < 24) begin : g_cw_narrow
        $error("fsr_timer: counter too narrow");
    end

    logic [CW-1:0] cnt_reg;

    // counter stops at zero so done fires exactly once per load
    always_ff @(posedge core_clk) begin
        if (!rstn || !run) begin
            cnt_reg <= '0;
            done    <= 1'h0;
        end else if (load) begin
            cnt_reg <= count;
            done    <= 1'h0;
        end else begin
            done    <= (cnt_reg == CW'(1));
            if (cnt_reg != '0) cnt_reg <= cnt_reg - CW'(1);
        end
    end
endmodule

// ===== pkg/fsr_defs.svh
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

// register offsets (index on the serial register port)
`define FSR_VRES_OFFSET        8'h1b
`define FSR_FCFG_OFFSET        8'h1c
`define FSR_VRES_RESET         16'h0000
`define FSR_FCFG_RESET         16'h0000
// writable bits of the fuse configuration register
`define FSR_FCFG_WMASK         16'hc7ff
// field positions
`define FSR_VCODE_LSB          0
`define FSR_VFRESH_BIT         10
`define FSR_NOM_LSB            0
`define FSR_TRIP_LSB           3
`define FSR_DCUR_LSB           7
`define FSR_DTMR_LSB           9
`define FSR_COOL_LSB           14
// timing figures: clock in megahertz, delays in microseconds, cool-downs in milliseconds
`define FSR_CLK_MHZ            200
`define FSR_DLY0_US            200
`define FSR_DLY1_US            400
`define FSR_DLY2_US            1000
`define FSR_DLY3_US            2000
`define FSR_COOL1_MS           800
`define FSR_COOL2_MS           2000
`define FSR_COOL3_MS           4000

`endif

// ===== pkg/fsr_pkg.sv
package fsr_pkg;

    // register access request from the serial port decoder
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } fsr_req_t;

    // decoded fuse configuration
    typedef struct packed {
        logic [1:0] cooldown;
        logic [1:0] dly_timer;
        logic [1:0] dly_current;
        logic [3:0] trip_level;
        logic [2:0] nominal;
    } fsr_cfg_t;

    typedef enum logic [2:0] {
        FSR_ON      = 3'b001,
        FSR_COOLING = 3'b010,
        FSR_LATCHED = 3'b100
    } fsr_state_t;

endpackage

// ===== verification/fsr_regs_checker.sv
`timescale 1ns/1ps
// ------------------------------
// register and protection checks
// ------------------------------
module fsr_regs_checker import fsr_pkg::*; #(parameter int COOL1_MS = 1, COOL2_MS = 1, COOL3_MS = 1) (
    input wire logic        core_clk,      // clock
    input wire logic        rstn,          // reset
    input wire fsr_req_t    req,           // access
    input wire logic [15:0] rdata,         // read data
    input wire logic        conv_valid,    // new code
    input wire logic [9:0]  conv_code,     // code
    input wire logic        over_current,  // over limit
    input wire logic        fuse_trip,     // energy trip
    input wire logic        restart,       // re-enable
    input wire fsr_cfg_t    cfg,           // fields
    input wire logic        channel_on,    // conducting
    input wire logic        fuse_off       // shutdown
);
    logic [19:0] oc_cnt;
    wire         rv = req.rd && req.addr == 8'h1b && !conv_valid;  // result read, no code arriving
    wire [12:0]  wf = {req.wdata[15:14], req.wdata[10:0]};
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // length of the present over-current stretch while conducting, to time the delayed turn-off
    always_ff @(posedge core_clk) oc_cnt <= (!rstn || !over_current || !channel_on) ? 20'h0 : oc_cnt + 20'h1;
    chk_code_fresh: assert property (conv_valid ##1 rv |=> rdata[10:0] == {1'b1, $past(conv_code, 2)})
        else $error("result read wrong");
    chk_fresh_clear: assert property (rv ##1 rv |=> !rdata[10]) else $error("fresh flag kept");
    chk_vres_zero: assert property (req.rd && req.addr == 8'h1b |=> rdata[15:11] == 5'h0)
        else $error("result high bits set");
    chk_fcfg_zero: assert property (req.rd && req.addr == 8'h1c |=> rdata[13:11] == 3'h0)
        else $error("config reserved set");
    chk_cfg_load: assert property (req.wr && req.addr == 8'h1c ##1 !req.wr |=> cfg == $past(wf, 2))
        else $error("fields not exported");
    chk_off_drop: assert property (fuse_off |=> !channel_on) else $error("channel kept on");
    chk_latch_hold: assert property (fuse_off && cfg.cooldown == 2'h0 ##1 !restart [*8] |=> !channel_on)
        else $error("latched channel retried");
    chk_trip_fast: assert property ($rose(fuse_trip) && channel_on |-> ##[1:3] fuse_off)
        else $error("energy trip missed");
    chk_delay_len: assert property (fuse_off && oc_cnt != 0 && cfg.dly_timer == 2'h0 |-> oc_cnt >= 39990 && oc_cnt <= 40010)
        else $error("delayed off time wrong");
endmodule
bind fsr_regs fsr_regs_checker #(.COOL1_MS(COOL1_MS), .COOL2_MS(COOL2_MS), .COOL3_MS(COOL3_MS)) u_chk (
    .core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata), .conv_valid(conv_valid), .conv_code(conv_code),
    .over_current(over_current), .fuse_trip(fuse_trip), .restart(restart), .cfg(cfg), .channel_on(channel_on),
    .fuse_off(fuse_off));

// ===== verification/test_fsr_regs.sv
`timescale 1ns/1ps
// ------------------------------
// register bank bench
// ------------------------------
module test_fsr_regs import fsr_pkg::*;;
    logic        core_clk = 1'h0, rstn = 1'h0, conv_valid = 1'h0, over_current = 1'h0, fuse_trip = 1'h0, restart = 1'h0;
    logic [9:0]  conv_code = 10'h0;
    fsr_req_t    req = '0;
    logic [15:0] rdata, d, d1;
    fsr_cfg_t    cfg;
    logic        channel_on, fuse_off;
    int          fail_count = 0, cmp_count = 0, cyc = 0, n;
    // write address, data, read address, expected read
    logic [15:0] rows [5][4] = '{'{16'h1c, 16'hffff, 16'h1c, 16'hc7ff}, '{16'h1d, 16'h0000, 16'h1c, 16'hc7ff},
        '{16'h1c, 16'h4a5d, 16'h1c, 16'h425d}, '{16'h1b, 16'hffff, 16'h1b, 16'h0000}, '{16'h1c, 16'h3800, 16'h1d, 16'h0000}};
    fsr_regs #(.COOL1_MS(1), .COOL2_MS(1), .COOL3_MS(1)) DUT (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
        .conv_valid(conv_valid), .conv_code(conv_code), .over_current(over_current), .fuse_trip(fuse_trip),
        .restart(restart), .cfg(cfg), .channel_on(channel_on), .fuse_off(fuse_off));
    // clock
    initial forever #2.5 core_clk = ~core_clk;
    // hang guard: the two delayed-off cases together need about 80000 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 90000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic tick(int k = 1);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    // k back-to-back accesses; an idle cycle after keeps strobes from toggling in one step
    task automatic acc(logic w, logic [7:0] a, logic [15:0] wd, int k = 1);
        req = '{w, !w, a, wd};
        repeat (k) begin
            tick();
            d1 = d;
            d = rdata;
        end
        req = '0;
        tick();
    endtask
    task automatic conv(logic [9:0] c);
        conv_code = c;
        conv_valid = 1'h1;
        tick();
        conv_valid = 1'h0;
    endtask
    // trip by energy, then hold off and re-enable
    task automatic shut(logic [15:0] wd);
        acc(1'h1, 8'h1c, wd);
        chk("on", {15'h0, channel_on}, 16'h1);
        fuse_trip = 1'h1;
        tick();
        fuse_trip = 1'h0;
        n = 0;
        while (fuse_off !== 1'h1 && n < 10) begin
            tick();
            n++;
        end
        chk("off", {15'h0, fuse_off}, 16'h1);
        tick(50);
        chk("held", {15'h0, channel_on}, 16'h0);
        restart = 1'h1;
        tick();
        restart = 1'h0;
        tick(4);
        chk("back", {15'h0, channel_on}, 16'h1);
    endtask
    initial begin
        tick(6);
        chk("rst rdata", rdata, 16'h0);
        chk("rst on", {15'h0, channel_on, fuse_off}, 16'h0);
        rstn = 1'h1;
        acc(1'h0, 8'h1b, 16'h0);
        chk("vres rst", d, 16'h0);
        acc(1'h0, 8'h1c, 16'h0);
        chk("fcfg rst", d, 16'h0);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            acc(1'h1, rows[i][0][7:0], rows[i][1]);
            acc(1'h0, rows[i][2][7:0], 16'h0);
            chk("read", d, rows[i][3]);
            if (rows[i][2] == 16'h1c) chk("cfg", 16'(cfg), {3'h0, rows[i][3][15:14], rows[i][3][10:0]});
        end
        $display("row test done");
        conv(10'h2a5);
        acc(1'h0, 8'h1b, 16'h0, 2);
        chk("vres new", d1, 16'h06a5);
        chk("vres old", d, 16'h02a5);
        conv(10'h3ff);
        conv_code = 10'h155;
        acc(1'h0, 8'h1b, 16'h0);
        chk("vres max", d, 16'h07ff);
        conv_valid = 1'h1;
        acc(1'h0, 8'h1b, 16'h0);
        chk("vres race rd", d, 16'h03ff);
        conv_valid = 1'h0;
        acc(1'h0, 8'h1b, 16'h0);
        chk("vres race", d, 16'h0555);
        $display("voltage test done");
        shut(16'h0000);
        shut(16'h4000);
        $display("fuse test done");
        // threshold code 0 at the nominal 700 ohm sense resistor: no scaling, inside the sensed range
        acc(1'h1, 8'h1c, 16'h4000);
        over_current = 1'h1;
        n = 0;
        while (fuse_off !== 1'h1 && n < 41000) begin
            tick();
            n++;
        end
        chk("delay", {15'h0, n >= 39990 && n <= 40010}, 16'h1);
        $display("delay test done");
        // current still high through a retry: a fresh window must trip again
        restart = 1'h1;
        tick();
        restart = 1'h0;
        tick(2);
        chk("retry on", {15'h0, channel_on}, 16'h1);
        n = 2;
        while (fuse_off !== 1'h1 && n < 41000) begin
            tick();
            n++;
        end
        chk("retry delay", {15'h0, n >= 39990 && n <= 40010}, 16'h1);
        over_current = 1'h0;
        $display("retry test done");
        give_verdict();
    end
endmodule
